// *** rtl/sws_host.sv ***
// host end of the single-wire link: start pulse, edge timing, frame decode
`timescale 1ns/1ps
module sws_host #(
    parameter logic [31:0] START_LOW_CYC = sws_pkg::START_LOW_CYC,
    parameter logic [31:0] GUARD_CYC = sws_pkg::GUARD_CYC,
    parameter logic [31:0] CYC_PER_US = sws_pkg::CYC_PER_US
) (
    input wire logic mclk,
    input wire logic nrst,
    sws_if.host lnk,
    input wire logic rd_req,
    output logic busy,
    output logic done,
    output logic err,
    output logic sum_ok,
    output logic [15:0] hum,
    output logic [15:0] temp
);
    typedef struct packed {
        sws_pkg::sws_host_st_t st;
        logic [31:0] cnt;
        logic [31:0] guard;
        logic [39:0] sh;
        logic [5:0] nbit;
        logic line_q;
        logic drv_oe;
        logic drv_lvl;
        logic busy;
        logic done;
        logic err;
        logic ok;
        logic [15:0] hum;
        logic [15:0] temp;
    } sws_host_state_t;

    localparam sws_host_state_t RST_STATE = '{
        st: sws_pkg::HOST_IDLE,
        cnt: 32'h0000_0000,
        guard: GUARD_CYC,
        sh: 40'h00_0000_0000,
        nbit: 6'h00,
        line_q: 1'b1,
        drv_oe: 1'b0,
        drv_lvl: 1'b0,
        busy: 1'b1,
        done: 1'b0,
        err: 1'b0,
        ok: 1'b0,
        hum: 16'h0000,
        temp: 16'h0000
    };

    sws_host_state_t cur_ff;
    sws_host_state_t nxt_cur;
    logic fall;
    logic rise;
    logic [7:0] sum_byte;

    assign fall = cur_ff.line_q & ~lnk.line;
    assign rise = ~cur_ff.line_q & lnk.line;
    assign sum_byte = 8'(cur_ff.sh[39:32] + cur_ff.sh[31:24] + cur_ff.sh[23:16] + cur_ff.sh[15:8]);

    // =====================================================================
    // sequencer
    always_comb begin
        nxt_cur = cur_ff;
        nxt_cur.line_q = lnk.line;
        nxt_cur.done = 1'b0;
        nxt_cur.drv_lvl = 1'b0;
        nxt_cur.cnt = cur_ff.cnt + 32'h0000_0001;
        if (cur_ff.guard != 32'h0000_0000) begin
            nxt_cur.guard = cur_ff.guard - 32'h0000_0001;
        end
        case (cur_ff.st)
            sws_pkg::HOST_IDLE: begin
                nxt_cur.drv_oe = 1'b0;
                nxt_cur.busy = (cur_ff.guard > 32'h0000_0001) || rd_req;
                if (rd_req && cur_ff.guard == 32'h0000_0000) begin
                    nxt_cur.drv_oe = 1'b1;
                    nxt_cur.err = 1'b0;
                    nxt_cur.cnt = 32'h0000_0000;
                    nxt_cur.st = sws_pkg::HOST_START;
                end
            end
            sws_pkg::HOST_START: begin
                if (nxt_cur.cnt >= START_LOW_CYC) begin
                    nxt_cur.drv_oe = 1'b0;
                    nxt_cur.cnt = 32'h0000_0000;
                    nxt_cur.st = sws_pkg::HOST_WAIT_REPLY;
                end
            end
            sws_pkg::HOST_WAIT_REPLY: begin
                if (fall) begin
                    nxt_cur.cnt = 32'h0000_0000;
                    nxt_cur.st = sws_pkg::HOST_REPLY_LOW;
                end
            end
            sws_pkg::HOST_REPLY_LOW: begin
                if (rise) begin
                    nxt_cur.cnt = 32'h0000_0000;
                    nxt_cur.st = sws_pkg::HOST_REPLY_HIGH;
                end
            end
            sws_pkg::HOST_REPLY_HIGH: begin
                if (fall) begin
                    nxt_cur.nbit = 6'h00;
                    nxt_cur.cnt = 32'h0000_0000;
                    nxt_cur.st = sws_pkg::HOST_BIT_LOW;
                end
            end
            sws_pkg::HOST_BIT_LOW: begin
                if (rise) begin
                    nxt_cur.cnt = 32'h0000_0000;
                    nxt_cur.st = sws_pkg::HOST_BIT_HIGH;
                end
            end
            sws_pkg::HOST_BIT_HIGH: begin
                if (fall) begin
                    nxt_cur.sh = {cur_ff.sh[38:0], cur_ff.cnt >= sws_pkg::BIT_THRESHOLD_US * CYC_PER_US};
                    nxt_cur.nbit = cur_ff.nbit + 6'h01;
                    nxt_cur.cnt = 32'h0000_0000;
                    if (cur_ff.nbit == sws_pkg::LAST_BIT) begin
                        nxt_cur.st = sws_pkg::HOST_WAIT_END;
                    end else begin
                        nxt_cur.st = sws_pkg::HOST_BIT_LOW;
                    end
                end
            end
            sws_pkg::HOST_WAIT_END: begin
                if (rise) begin
                    nxt_cur.hum = cur_ff.sh[39:24];
                    nxt_cur.temp = cur_ff.sh[23:8];
                    nxt_cur.ok = (sum_byte == cur_ff.sh[7:0]);
                    nxt_cur.done = 1'b1;
                    nxt_cur.guard = GUARD_CYC;
                    nxt_cur.st = sws_pkg::HOST_IDLE;
                end
            end
            default: begin
                nxt_cur = RST_STATE;
            end
        endcase
        // any awaited edge that does not come in time ends the read
        if (cur_ff.st != sws_pkg::HOST_IDLE && cur_ff.st != sws_pkg::HOST_START &&
            nxt_cur.st == cur_ff.st && cur_ff.cnt >= sws_pkg::EDGE_TIMEOUT_US * CYC_PER_US) begin
            nxt_cur.err = 1'b1;
            nxt_cur.done = 1'b1;
            nxt_cur.ok = 1'b0;
            nxt_cur.guard = GUARD_CYC;
            nxt_cur.st = sws_pkg::HOST_IDLE;
        end
    end

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            cur_ff <= RST_STATE;
        end else begin
            cur_ff <= nxt_cur;
        end
    end

    // =====================================================================
    // outputs
    assign lnk.host_oe = cur_ff.drv_oe;
    assign lnk.host_out = cur_ff.drv_lvl;
    assign busy = cur_ff.busy;
    assign done = cur_ff.done;
    assign err = cur_ff.err;
    assign sum_ok = cur_ff.ok;
    assign hum = cur_ff.hum;
    assign temp = cur_ff.temp;
endmodule : sws_host

// *** rtl/sws_if.sv ***
// interface joining host and sensor on the open-drain data line
`timescale 1ns/1ps
interface sws_if;
    logic host_out;
    logic host_oe;
    logic sens_out;
    logic sens_oe;
    logic line;

    // =====================================================================
    // wired level: pull-up unless an enabled driver pulls low
    assign line = ~((host_oe & ~host_out) | (sens_oe & ~sens_out));

    modport host (output host_out, output host_oe, input line);
    modport sensor (output sens_out, output sens_oe, input line);
endinterface : sws_if

// *** rtl/sws_pkg.sv ***
// package with timing constants, frame layout and state types of the single-wire sensor link
package sws_pkg;
    // =====================================================================
    // clock
    localparam logic [31:0] CLK_MHZ = 32'd125;
    localparam logic [31:0] CYC_PER_US = CLK_MHZ;

    // =====================================================================
    // line timing in microseconds (start and guard in their own units)
    localparam logic [31:0] START_MIN_US = 32'd800;
    localparam logic [31:0] START_LOW_MS = 32'd1;
    localparam logic [31:0] START_MAX_MS = 32'd20;
    localparam logic [31:0] HOST_RELEASE_MIN_US = 32'd10;
    localparam logic [31:0] HOST_RELEASE_TYP_US = 32'd20;
    localparam logic [31:0] HOST_RELEASE_MAX_US = 32'd200;
    localparam logic [31:0] REPLY_LOW_US = 32'd80;
    localparam logic [31:0] REPLY_HIGH_US = 32'd80;
    localparam logic [31:0] BIT_LOW_US = 32'd50;
    localparam logic [31:0] ZERO_HIGH_US = 32'd26;
    localparam logic [31:0] ONE_HIGH_US = 32'd70;
    localparam logic [31:0] SENSOR_RELEASE_US = 32'd50;
    localparam logic [31:0] BIT_THRESHOLD_US = 32'd48;
    localparam logic [31:0] EDGE_TIMEOUT_US = 32'd250;
    localparam logic [31:0] MEASURE_US = 32'd20;
    localparam logic [31:0] GUARD_S = 32'd2;

    // =====================================================================
    // derived cycle counts
    localparam logic [31:0] START_MIN_CYC = START_MIN_US * CYC_PER_US;
    localparam logic [31:0] START_LOW_CYC = START_LOW_MS * 32'd1000 * CYC_PER_US;
    localparam logic [31:0] HOST_RELEASE_CYC = HOST_RELEASE_TYP_US * CYC_PER_US;
    localparam logic [31:0] REPLY_LOW_CYC = REPLY_LOW_US * CYC_PER_US;
    localparam logic [31:0] REPLY_HIGH_CYC = REPLY_HIGH_US * CYC_PER_US;
    localparam logic [31:0] BIT_LOW_CYC = BIT_LOW_US * CYC_PER_US;
    localparam logic [31:0] ZERO_HIGH_CYC = ZERO_HIGH_US * CYC_PER_US;
    localparam logic [31:0] ONE_HIGH_CYC = ONE_HIGH_US * CYC_PER_US;
    localparam logic [31:0] SENSOR_RELEASE_CYC = SENSOR_RELEASE_US * CYC_PER_US;
    localparam logic [31:0] BIT_THRESHOLD_CYC = BIT_THRESHOLD_US * CYC_PER_US;
    localparam logic [31:0] EDGE_TIMEOUT_CYC = EDGE_TIMEOUT_US * CYC_PER_US;
    localparam logic [31:0] MEASURE_CYC = MEASURE_US * CYC_PER_US;
    localparam logic [31:0] GUARD_CYC = GUARD_S * 32'd1000000 * CYC_PER_US;

    // =====================================================================
    // frame layout
    localparam logic [5:0] FRAME_BITS = 6'h28;
    localparam logic [5:0] LAST_BIT = 6'h27;

    // =====================================================================
    // states
    typedef enum logic [2:0] {
        SENS_MEASURE, SENS_SLEEP, SENS_GO, SENS_REPLY_LOW, SENS_REPLY_HIGH,
        SENS_BIT_LOW, SENS_BIT_HIGH, SENS_END_LOW
    } sws_sens_st_t;

    typedef enum logic [2:0] {
        HOST_IDLE, HOST_START, HOST_WAIT_REPLY, HOST_REPLY_LOW, HOST_REPLY_HIGH,
        HOST_BIT_LOW, HOST_BIT_HIGH, HOST_WAIT_END
    } sws_host_st_t;
endpackage : sws_pkg

// *** rtl/sws_sensor.sv ***
// sensor end of the single-wire link: start detect, reply, 40-bit frame
`timescale 1ns/1ps
module sws_sensor #(
    parameter logic [31:0] START_MIN_CYC = sws_pkg::START_MIN_CYC,
    parameter logic [31:0] CYC_PER_US = sws_pkg::CYC_PER_US
) (
    input wire logic mclk,
    input wire logic nrst,
    sws_if.sensor lnk,
    input wire logic [15:0] hum_val,
    input wire logic [15:0] temp_val,
    output logic sleeping,
    output logic sample_pulse
);
    typedef struct packed {
        sws_pkg::sws_sens_st_t st;
        logic [31:0] cnt;
        logic [39:0] frame;
        logic [5:0] nbit;
        logic [15:0] hum;
        logic [15:0] temp;
        logic drv_oe;
        logic drv_lvl;
        logic sleep;
        logic sample;
    } sws_sens_state_t;

    localparam sws_sens_state_t RST_STATE = '{
        st: sws_pkg::SENS_MEASURE,
        cnt: 32'h0000_0000,
        frame: 40'h00_0000_0000,
        nbit: 6'h00,
        hum: 16'h0000,
        temp: 16'h0000,
        drv_oe: 1'b0,
        drv_lvl: 1'b0,
        sleep: 1'b0,
        sample: 1'b0
    };

    sws_sens_state_t cur_ff;
    sws_sens_state_t nxt_cur;
    logic [7:0] sum_byte;
    logic [31:0] cnt_inc;
    logic [31:0] phase_len;

    // =====================================================================
    // checksum over the stored bytes
    assign sum_byte = 8'(cur_ff.hum[15:8] + cur_ff.hum[7:0] + cur_ff.temp[15:8] + cur_ff.temp[7:0]);
    assign cnt_inc = cur_ff.cnt + 32'h0000_0001;

    // =====================================================================
    // length of the current phase, scaled by the clock rate in one place
    always_comb begin
        phase_len = 32'h0000_0000;
        case (cur_ff.st)
            sws_pkg::SENS_MEASURE: begin
                phase_len = sws_pkg::MEASURE_US * CYC_PER_US;
            end
            sws_pkg::SENS_GO: begin
                phase_len = sws_pkg::HOST_RELEASE_TYP_US * CYC_PER_US;
            end
            sws_pkg::SENS_REPLY_LOW: begin
                phase_len = sws_pkg::REPLY_LOW_US * CYC_PER_US;
            end
            sws_pkg::SENS_REPLY_HIGH: begin
                phase_len = sws_pkg::REPLY_HIGH_US * CYC_PER_US;
            end
            sws_pkg::SENS_BIT_LOW: begin
                phase_len = sws_pkg::BIT_LOW_US * CYC_PER_US;
            end
            sws_pkg::SENS_BIT_HIGH: begin
                if (cur_ff.frame[39]) begin
                    phase_len = sws_pkg::ONE_HIGH_US * CYC_PER_US;
                end else begin
                    phase_len = sws_pkg::ZERO_HIGH_US * CYC_PER_US;
                end
            end
            sws_pkg::SENS_END_LOW: begin
                phase_len = sws_pkg::SENSOR_RELEASE_US * CYC_PER_US;
            end
            default: begin
                phase_len = 32'h0000_0000;
            end
        endcase
    end

    // =====================================================================
    // sequencer
    always_comb begin
        nxt_cur = cur_ff;
        nxt_cur.sample = 1'b0;
        nxt_cur.drv_lvl = 1'b0;
        nxt_cur.cnt = cnt_inc;
        case (cur_ff.st)
            sws_pkg::SENS_MEASURE: begin
                nxt_cur.drv_oe = 1'b0;
                if (cnt_inc >= phase_len) begin
                    // sensing result is latched and held for the next read
                    nxt_cur.hum = hum_val;
                    nxt_cur.temp = temp_val;
                    nxt_cur.sample = 1'b1;
                    nxt_cur.sleep = 1'b1;
                    nxt_cur.cnt = 32'h0000_0000;
                    nxt_cur.st = sws_pkg::SENS_SLEEP;
                end
            end
            sws_pkg::SENS_SLEEP: begin
                nxt_cur.drv_oe = 1'b0;
                if (!lnk.line) begin
                    // saturate so a long start cannot wrap back below the minimum
                    if (cur_ff.cnt >= START_MIN_CYC) begin
                        nxt_cur.cnt = cur_ff.cnt;
                    end
                end else if (cur_ff.cnt >= START_MIN_CYC) begin
                    // frame built from stored values, not a fresh sample
                    nxt_cur.frame = {cur_ff.hum, cur_ff.temp, sum_byte};
                    nxt_cur.sleep = 1'b0;
                    nxt_cur.cnt = 32'h0000_0000;
                    nxt_cur.st = sws_pkg::SENS_GO;
                end else begin
                    nxt_cur.cnt = 32'h0000_0000;
                end
            end
            sws_pkg::SENS_GO: begin
                if (cnt_inc >= phase_len) begin
                    nxt_cur.drv_oe = 1'b1;
                    nxt_cur.cnt = 32'h0000_0000;
                    nxt_cur.st = sws_pkg::SENS_REPLY_LOW;
                end
            end
            sws_pkg::SENS_REPLY_LOW: begin
                if (cnt_inc >= phase_len) begin
                    nxt_cur.drv_oe = 1'b0;
                    nxt_cur.cnt = 32'h0000_0000;
                    nxt_cur.st = sws_pkg::SENS_REPLY_HIGH;
                end
            end
            sws_pkg::SENS_REPLY_HIGH: begin
                if (cnt_inc >= phase_len) begin
                    nxt_cur.drv_oe = 1'b1;
                    nxt_cur.nbit = 6'h00;
                    nxt_cur.cnt = 32'h0000_0000;
                    nxt_cur.st = sws_pkg::SENS_BIT_LOW;
                end
            end
            sws_pkg::SENS_BIT_LOW: begin
                if (cnt_inc >= phase_len) begin
                    nxt_cur.drv_oe = 1'b0;
                    nxt_cur.cnt = 32'h0000_0000;
                    nxt_cur.st = sws_pkg::SENS_BIT_HIGH;
                end
            end
            sws_pkg::SENS_BIT_HIGH: begin
                if (cnt_inc >= phase_len) begin
                    nxt_cur.frame = {cur_ff.frame[38:0], 1'b0};
                    nxt_cur.nbit = cur_ff.nbit + 6'h01;
                    nxt_cur.drv_oe = 1'b1;
                    nxt_cur.cnt = 32'h0000_0000;
                    if (cur_ff.nbit == sws_pkg::LAST_BIT) begin
                        nxt_cur.st = sws_pkg::SENS_END_LOW;
                    end else begin
                        nxt_cur.st = sws_pkg::SENS_BIT_LOW;
                    end
                end
            end
            sws_pkg::SENS_END_LOW: begin
                if (cnt_inc >= phase_len) begin
                    nxt_cur.drv_oe = 1'b0;
                    nxt_cur.cnt = 32'h0000_0000;
                    nxt_cur.st = sws_pkg::SENS_MEASURE;
                end
            end
            default: begin
                nxt_cur = RST_STATE;
            end
        endcase
    end

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            cur_ff <= RST_STATE;
        end else begin
            cur_ff <= nxt_cur;
        end
    end

    // =====================================================================
    // outputs
    assign lnk.sens_oe = cur_ff.drv_oe;
    assign lnk.sens_out = cur_ff.drv_lvl;
    assign sleeping = cur_ff.sleep;
    assign sample_pulse = cur_ff.sample;
endmodule : sws_sensor

// *** sim/single_wire_sensor_read_tb.sv ***
// self-checking bench: host and sensor ends joined on one line
`timescale 1ns/1ps
module single_wire_sensor_read_tb;
    // one clock per microsecond keeps each frame a few thousand cycles
    localparam logic [31:0] CPU = 32'h1;
    localparam logic [31:0] SMIN = 32'h320;
    localparam logic [31:0] SLOW = 32'h3E8;
    localparam logic [31:0] GRD = 32'd50;
    logic mclk = 1'b0;
    logic nrst = 1'b0;
    logic sens_run = 1'b1;
    logic sens_nrst;
    logic rd_req = 1'b0;
    logic [15:0] hum_val = 16'h0292;
    logic [15:0] temp_val = 16'h010D;
    logic sleeping, sample_pulse, busy, done, err, sum_ok;
    logic [15:0] hum, temp;
    logic [39:0] wire_bits = 40'h0;
    int wire_n = 0;
    int hi_len = 0;
    int err_total = 0;
    int checks_done = 0;

    sws_if sws_if_i ();
    assign sens_nrst = nrst & sens_run;

    sws_sensor #(.START_MIN_CYC(SMIN), .CYC_PER_US(CPU)) sws_sensor_i (.mclk(mclk), .nrst(sens_nrst),
        .lnk(sws_if_i.sensor), .hum_val(hum_val), .temp_val(temp_val), .sleeping(sleeping),
        .sample_pulse(sample_pulse));
    sws_host #(.START_LOW_CYC(SLOW), .GUARD_CYC(GRD), .CYC_PER_US(CPU)) sws_host_i (.mclk(mclk), .nrst(nrst),
        .lnk(sws_if_i.host), .rd_req(rd_req), .busy(busy), .done(done), .err(err), .sum_ok(sum_ok),
        .hum(hum), .temp(temp));
    sws_monitor #(.START_MIN_CYC(SMIN), .CYC_PER_US(CPU)) sws_monitor_i (.mclk(mclk), .nrst(nrst),
        .host_out(sws_if_i.host_out), .host_oe(sws_if_i.host_oe), .sens_out(sws_if_i.sens_out),
        .sens_oe(sws_if_i.sens_oe), .line(sws_if_i.line));

    initial begin
        forever #4 mclk = ~mclk;
    end

    // =====================================================================
    // own decode of the wire: each line fall after a bit high shifts in one bit
    always @(posedge mclk) begin
        hi_len <= sws_if_i.line ? hi_len + 1 : 0;
        if (sws_if_i.host_oe) begin
            wire_n <= 0;
        end else if (!sws_if_i.line && hi_len > 0 && wire_n < 42) begin
            wire_n <= wire_n + 1;
            if (wire_n >= 2) begin
                wire_bits <= {wire_bits[38:0], hi_len > 48 * int'(CPU)};
            end
        end
    end

    task automatic cmp(input string what, input logic [39:0] exp, input logic [39:0] got);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : cmp

    function automatic logic pick(input string what);
        case (what)
            "busy": pick = busy;
            "done": pick = done;
            "sample": pick = sample_pulse;
            default: pick = sleeping;
        endcase
    endfunction : pick

    task automatic wait_lvl(input string what, input logic val);
        int n;
        n = 0;
        while (pick(what) !== val && n < 20000) begin
            @(posedge mclk);
            #1;
            n++;
        end
        cmp(what, {39'h0, val}, {39'h0, pick(what)});
    endtask : wait_lvl

    task automatic request();
        wait_lvl("busy", 1'b0);
        rd_req = 1'b1;
        @(posedge mclk);
        #1;
        rd_req = 1'b0;
        wait_lvl("done", 1'b1);
    endtask : request

    // a request while busy must not start a pulse
    task automatic poke_busy();
        rd_req = 1'b1;
        @(posedge mclk);
        #1;
        rd_req = 1'b0;
        repeat (3) @(posedge mclk);
        #1;
        cmp("start while busy", 40'h0, {39'h0, sws_if_i.host_oe});
    endtask : poke_busy

    task automatic read_frame(input string name, input logic [15:0] eh, input logic [15:0] et);
        logic [7:0] es;
        es = eh[15:8] + eh[7:0] + et[15:8] + et[7:0];
        request();
        cmp("hum", {24'h0, eh}, {24'h0, hum});
        cmp("temp", {24'h0, et}, {24'h0, temp});
        cmp("sum_ok", 40'h1, {39'h0, sum_ok});
        cmp("err", 40'h0, {39'h0, err});
        poke_busy();
        wait_lvl("sleeping", 1'b1);
        cmp("wire edges", 40'd42, 40'(wire_n));
        cmp("wire bits", {eh, et, es}, wire_bits);
        $display("test %s finished", name);
    endtask : read_frame

    task automatic stop_test();
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : stop_test

    initial begin
        repeat (3) @(posedge mclk);
        #1;
        nrst = 1'b1;
        poke_busy();
        wait_lvl("sample", 1'b1);
        hum_val = 16'h03E8;
        temp_val = 16'h8065;
        read_frame("power-on value", 16'h0292, 16'h010D);
        hum_val = 16'hFFFF;
        temp_val = 16'hFFFF;
        read_frame("negative carry", 16'h03E8, 16'h8065);
        // silent sensor: the host must give up and flag it
        sens_run = 1'b0;
        request();
        cmp("err", 40'h1, {39'h0, err});
        cmp("sum_ok", 40'h0, {39'h0, sum_ok});
        sens_run = 1'b1;
        $display("test silent sensor finished");
        stop_test();
    end

    initial begin
        #(8 * 40000);
        err_total++;
        $display("CHECK FAILED watchdog expected finish seen timeout");
        stop_test();
    end
endmodule : single_wire_sensor_read_tb

// *** sim/sws_monitor.sv ***
// concurrent checks on the single-wire line between the host and sensor ends
`timescale 1ns/1ps
module sws_monitor #(
    parameter logic [31:0] START_MIN_CYC = sws_pkg::START_MIN_CYC,
    parameter logic [31:0] CYC_PER_US = sws_pkg::CYC_PER_US
) (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic host_out,
    input wire logic host_oe,
    input wire logic sens_out,
    input wire logic sens_oe,
    input wire logic line
);
    localparam int US = int'(CYC_PER_US);
    localparam int START_MAX = 20000 * US;
    // =====================================================================
    // run-length helpers
    logic [31:0] lo_cnt_ff;
    logic [31:0] hi_cnt_ff;
    logic [31:0] st_cnt_ff;
    logic [5:0] nf_ff;
    logic oe_q_ff;

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            lo_cnt_ff <= 32'h0;
            hi_cnt_ff <= 32'h0;
            st_cnt_ff <= 32'h0;
            nf_ff <= 6'h0;
            oe_q_ff <= 1'b0;
        end else begin
            lo_cnt_ff <= sens_oe ? lo_cnt_ff + 32'h1 : 32'h0;
            hi_cnt_ff <= line ? hi_cnt_ff + 32'h1 : 32'h0;
            st_cnt_ff <= host_oe ? st_cnt_ff + 32'h1 : 32'h0;
            oe_q_ff <= sens_oe;
            // low phases finished by the sensor since the last start
            if (host_oe) begin
                nf_ff <= 6'h0;
            end else if (oe_q_ff && !sens_oe) begin
                nf_ff <= nf_ff + 6'h1;
            end
        end
    end

    default clocking @(posedge mclk); endclocking
    default disable iff (!nrst);

    // =====================================================================
    // frame phases
    sequence s_low_end(int k);
        $fell(sens_oe) && nf_ff == k;
    endsequence
    sequence s_high_end(int k);
        $rose(sens_oe) && nf_ff == k;
    endsequence

    host_drive_low_a: assert property (host_oe |-> !host_out)
        else $error("host drives the line high");
    sens_drive_low_a: assert property (sens_oe |-> !sens_out)
        else $error("sensor drives the line high");
    no_clash_a: assert property (host_oe |-> !sens_oe)
        else $error("sensor drives during host start");
    start_len_a: assert property ($fell(host_oe) |-> st_cnt_ff >= START_MIN_CYC && st_cnt_ff <= START_MAX)
        else $error("start pulse length out of range");
    wake_gap_a: assert property (s_high_end(0) |-> hi_cnt_ff >= 10 * US && hi_cnt_ff <= 200 * US)
        else $error("gap before reply out of range");
    reply_low_a: assert property (s_low_end(0) |-> lo_cnt_ff >= 75 * US && lo_cnt_ff <= 85 * US)
        else $error("reply low length out of range");
    reply_high_a: assert property (s_high_end(1) |-> hi_cnt_ff >= 75 * US && hi_cnt_ff <= 85 * US)
        else $error("reply high length out of range");
    bit_low_a: assert property ($fell(sens_oe) && nf_ff >= 1 && nf_ff <= 40
        |-> lo_cnt_ff >= 48 * US && lo_cnt_ff <= 55 * US)
        else $error("bit low length out of range");
    bit_high_a: assert property ($rose(sens_oe) && nf_ff >= 2 |-> (hi_cnt_ff >= 22 * US && hi_cnt_ff <= 30 * US)
        || (hi_cnt_ff >= 68 * US && hi_cnt_ff <= 75 * US))
        else $error("bit high length out of range");
    final_low_a: assert property (s_low_end(41) |-> lo_cnt_ff >= 45 * US && lo_cnt_ff <= 55 * US)
        else $error("final low length out of range");
    release_hold_a: assert property (s_low_end(41) |=> !sens_oe [*8])
        else $error("sensor drives after final release");
    frame_count_a: assert property ($rose(host_oe) |-> nf_ff == 6'h0 || nf_ff == 6'h2A)
        else $error("previous frame had wrong number of phases");
endmodule : sws_monitor
